// file: src/fdpw_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the
  data flash page writer. Assumes a 125 MHz system clock.
*/
`ifndef FDPW_REGS_SVH
`define FDPW_REGS_SVH

`define FDPW_CTRL_OFS      8'h00
`define FDPW_STAT_OFS      8'h04
`define FDPW_EMUT_OFS      8'h08

`define FDPW_CTRL_RST      8'h00
`define FDPW_EMUT_RST      16'h0100

`define FDPW_CODE_WR_ON    8'h3b
`define FDPW_CODE_WR_OFF   8'hcb
`define FDPW_CTRL_PWR      0

`define FDPW_STAT_BUSY     0
`define FDPW_STAT_WUP      1
`define FDPW_STAT_ABT      2

`define FDPW_READ_BLANK    8'hff
`define FDPW_PAGE_BYTES    7'd64
`define FDPW_FLASH_BASE    16'h8000
`define FDPW_MCU_TOP       16'h81ff

`define FDPW_WARM_HF_CYC   11'd1024
`define FDPW_WARM_LF_TICKS 11'd8

`define FDPW_CLK_PERIOD_NS 8
`define FDPW_PROG_TIME_NS  4000000
`define FDPW_PROG_CYC      (`FDPW_PROG_TIME_NS / `FDPW_CLK_PERIOD_NS)
`define FDPW_EMU_UNIT_SHIFT 8

`endif

// file: src/fdpw_pkg.sv
/*
  Types of the data flash page writer.
  Assumes nothing of its surroundings.
*/
package fdpw_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FILL,
    ST_WAIT,
    ST_ERASE,
    ST_COPY,
    ST_WARM
  } fdpw_state_t;

endpackage

// file: src/fdpw_page_buf.sv
/*
  Temporary 64-byte page data buffer: two write ports, one registered
  read port. Assumes both write ports never aim at one position.
*/
`timescale 1ns/1ps
`default_nettype none

module fdpw_page_buf (
  input  wire logic       clk,
  input  wire logic       wa_en,
  input  wire logic [5:0] wa_addr,
  input  wire logic [7:0] wa_data,
  input  wire logic       wb_en,
  input  wire logic [5:0] wb_addr,
  input  wire logic [7:0] wb_data,
  input  wire logic [5:0] r_addr,
  output logic      [7:0] r_data
);

  logic [7:0] mem [0:63];

  always_ff @(posedge clk)
  begin
    if (wa_en)
    begin
      mem[wa_addr] <= wa_data;
    end
    if (wb_en)
    begin
      mem[wb_addr] <= wb_data;
    end
    r_data <= mem[r_addr];
  end

endmodule

`default_nettype wire

// file: src/fdpw_top.sv
/*
  Data flash page writer: CPU store and load port, Wishbone register
  slave and page buffer sequencer towards the flash array.
  Assumes the CPU holds a memory request for one cycle and waits for
  MEM_ACK, and that the flash array answers reads in the same cycle.
*/
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fdpw_regs.svh"

module fdpw_top #(
  parameter bit EMULATION = 1'b0,
  parameter int PROG_CYC  = `FDPW_PROG_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic        MEM_WORD,
  input  wire logic        MEM_FETCH,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [15:0] MEM_WDATA,
  output logic      [7:0]  MEM_RDATA,
  output logic             MEM_ACK,
  output logic             SWI_REQ,
  input  wire logic        NMI,
  input  wire logic        SYS_CLK_SEL,
  input  wire logic        LF_TICK,
  input  wire logic        PROM_MODE,
  output logic             CPU_WAIT,
  output logic             WR_BUSY,
  output logic             FL_RD_EN,
  output logic      [15:0] FL_RD_ADDR,
  input  wire logic [7:0]  FL_RDATA,
  output logic             FL_ERASE,
  output logic      [9:0]  FL_PAGE,
  output logic             FL_WR_EN,
  output logic      [15:0] FL_WR_ADDR,
  output logic      [7:0]  FL_WR_DATA
);

  fdpw_pkg::fdpw_state_t st_q;
  logic [6:0]  cnt_q;
  logic [9:0]  page_q;
  logic [23:0] tmr_q;
  logic [10:0] warm_q;
  logic [6:0]  cp_q;
  logic        warm_done_q;
  logic        abort_q;
  logic        wr_en_q;
  logic [7:0]  ctrl_q;
  logic [15:0] emut_q;
  logic        wb_ack_q;
  logic        p_vld_q;
  logic        p_we_q;
  logic        p_fetch_q;
  logic        p_blk_q;
  logic [7:0]  buf_rdata;
  logic [31:0] rd_word;

  logic busy_st;
  logic busy;
  logic blocked;
  logic abort_ev;
  logic addr_ok;
  logic store;
  logic room2;
  logic [6:0] cnt_nx;
  logic wb_req;
  logic wb_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic warm_tick;
  logic [10:0] warm_len;

  // Length of the wait phase in clock cycles, before erase and copy
  function automatic logic [23:0] busy_len(input logic [15:0] t);
    logic [23:0] v;
    v = 24'h0;
    if (EMULATION)
    begin
      v = {t, 8'h00} >> (8 - `FDPW_EMU_UNIT_SHIFT);
      if (t == 16'h0000)
      begin
        v = 24'h000001;
      end
    end
    else
    begin
      v = PROG_CYC[23:0];
    end
    return v;
  endfunction

  assign busy_st = (st_q == fdpw_pkg::ST_WAIT) ||
                   (st_q == fdpw_pkg::ST_ERASE) ||
                   (st_q == fdpw_pkg::ST_COPY);
  assign busy    = busy_st || FL_WR_EN;
  assign WR_BUSY = busy;
  assign CPU_WAIT = (st_q == fdpw_pkg::ST_WARM);
  assign blocked = busy || !warm_done_q || CPU_WAIT;
  // Abort during buffering too, so a short page is never written
  assign abort_ev = NMI && (busy ||
                    (st_q == fdpw_pkg::ST_FILL));
  assign addr_ok = (MEM_ADDR >= `FDPW_FLASH_BASE) &&
                   (PROM_MODE || (MEM_ADDR <= `FDPW_MCU_TOP));
  assign store = MEM_REQ && MEM_WE && wr_en_q && warm_done_q &&
                 addr_ok && !abort_ev &&
                 ((st_q == fdpw_pkg::ST_IDLE) ||
                  (st_q == fdpw_pkg::ST_FILL));
  assign room2  = MEM_WORD && (cnt_q < 7'd63);
  assign cnt_nx = cnt_q + (room2 ? 7'd2 : 7'd1);
  assign warm_tick = SYS_CLK_SEL ? LF_TICK : 1'b1;
  assign warm_len  = SYS_CLK_SEL ? `FDPW_WARM_LF_TICKS
                                 : `FDPW_WARM_HF_CYC;

  fdpw_page_buf u_buf (
    .clk     (CLK),
    .wa_en   (store),
    .wa_addr (cnt_q[5:0]),
    .wa_data (MEM_WDATA[7:0]),
    .wb_en   (store && room2),
    .wb_addr (cnt_q[5:0] + 6'd1),
    .wb_data (MEM_WDATA[15:8]),
    .r_addr  (cp_q[5:0]),
    .r_data  (buf_rdata)
  );

  // Sequencer
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q   <= fdpw_pkg::ST_WARM;
      cnt_q  <= 7'd0;
      page_q <= 10'h000;
      tmr_q  <= 24'h000000;
      warm_q <= 11'd0;
      cp_q   <= 7'd0;
    end
    else if (abort_ev)
    begin
      st_q   <= fdpw_pkg::ST_WARM;
      cnt_q  <= 7'd0;
      warm_q <= 11'd0;
      cp_q   <= 7'd0;
    end
    else
    begin
      unique case (st_q)
        fdpw_pkg::ST_IDLE, fdpw_pkg::ST_FILL:
        begin
          if (store)
          begin
            if (st_q == fdpw_pkg::ST_IDLE)
            begin
              page_q <= MEM_ADDR[15:6];
            end
            if (cnt_nx == `FDPW_PAGE_BYTES)
            begin
              st_q  <= fdpw_pkg::ST_WAIT;
              cnt_q <= 7'd0;
              tmr_q <= busy_len(emut_q);
            end
            else
            begin
              st_q  <= fdpw_pkg::ST_FILL;
              cnt_q <= cnt_nx;
            end
          end
          else if (ctrl_wr && WB_DAT_I[`FDPW_CTRL_PWR] && !warm_done_q)
          begin
            st_q   <= fdpw_pkg::ST_WARM;
            warm_q <= 11'd0;
          end
        end
        fdpw_pkg::ST_WAIT:
        begin
          if (tmr_q <= 24'h000001)
          begin
            st_q <= fdpw_pkg::ST_ERASE;
          end
          else
          begin
            tmr_q <= tmr_q - 24'h000001;
          end
        end
        fdpw_pkg::ST_ERASE:
        begin
          st_q <= fdpw_pkg::ST_COPY;
          cp_q <= 7'd0;
        end
        fdpw_pkg::ST_COPY:
        begin
          cp_q <= cp_q + 7'd1;
          if (cp_q == `FDPW_PAGE_BYTES)
          begin
            st_q <= fdpw_pkg::ST_IDLE;
            cp_q <= 7'd0;
          end
        end
        fdpw_pkg::ST_WARM:
        begin
          if (warm_tick)
          begin
            warm_q <= warm_q + 11'd1;
            if (warm_q + 11'd1 >= warm_len)
            begin
              st_q <= fdpw_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Warm-up done flag
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      warm_done_q <= 1'b0;
    end
    else if (abort_ev)
    begin
      warm_done_q <= 1'b0;
    end
    else if (CPU_WAIT && warm_tick && (warm_q + 11'd1 >= warm_len))
    begin
      warm_done_q <= 1'b1;
    end
  end

  // Flash array drive: erase pulse, then one byte per cycle
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FL_ERASE   <= 1'b0;
      FL_PAGE    <= 10'h000;
      FL_WR_EN   <= 1'b0;
      FL_WR_ADDR <= 16'h0000;
      FL_WR_DATA <= 8'h00;
    end
    else
    begin
      FL_ERASE <= (st_q == fdpw_pkg::ST_ERASE) && !abort_ev;
      FL_PAGE  <= page_q;
      FL_WR_EN <= (st_q == fdpw_pkg::ST_COPY) && (cp_q != 7'd0) &&
                  !abort_ev;
      if ((st_q == fdpw_pkg::ST_COPY) && (cp_q != 7'd0))
      begin
        FL_WR_ADDR <= {page_q, cp_q[5:0] - 6'd1};
        FL_WR_DATA <= buf_rdata;
      end
    end
  end

  // CPU memory port: request, then answer two cycles on
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      p_vld_q    <= 1'b0;
      p_we_q     <= 1'b0;
      p_fetch_q  <= 1'b0;
      p_blk_q    <= 1'b0;
      FL_RD_EN   <= 1'b0;
      FL_RD_ADDR <= 16'h0000;
      MEM_ACK    <= 1'b0;
      MEM_RDATA  <= 8'h00;
      SWI_REQ    <= 1'b0;
    end
    else
    begin
      p_vld_q   <= MEM_REQ;
      p_we_q    <= MEM_WE;
      p_fetch_q <= MEM_FETCH;
      p_blk_q   <= blocked;
      FL_RD_EN  <= MEM_REQ && !MEM_WE && !blocked;
      if (MEM_REQ)
      begin
        FL_RD_ADDR <= MEM_ADDR;
      end
      MEM_ACK <= p_vld_q;
      SWI_REQ <= p_vld_q && !p_we_q && p_fetch_q && p_blk_q;
      if (p_vld_q && !p_we_q)
      begin
        MEM_RDATA <= p_blk_q ? `FDPW_READ_BLANK : FL_RDATA;
      end
    end
  end

  // Wishbone slave, answer one cycle after the request
  assign wb_req  = WB_CYC_I && WB_STB_I;
  assign wb_wr   = wb_ack_q && wb_req && WB_WE_I;
  assign ctrl_wr = wb_wr && (WB_ADR_I == `FDPW_CTRL_OFS) && WB_SEL_I[0];
  assign stat_wr = wb_wr && (WB_ADR_I == `FDPW_STAT_OFS) && WB_SEL_I[0];
  assign WB_ACK_O = wb_ack_q;

  always_comb
  begin
    rd_word = 32'h00000000;
    case (WB_ADR_I)
      `FDPW_CTRL_OFS: rd_word = {24'h000000, ctrl_q};
      `FDPW_STAT_OFS: rd_word = {18'h00000, cnt_q[5:0], 5'h00,
                                 abort_q, warm_done_q, busy};
      `FDPW_EMUT_OFS: rd_word = {16'h0000, emut_q};
      default:        rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wb_ack_q <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      wb_ack_q <= wb_req && !wb_ack_q;
      WB_DAT_O <= (wb_req && !wb_ack_q && !WB_WE_I) ? rd_word
                                                    : 32'h00000000;
    end
  end

  // Control register and write enable codes
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_q  <= `FDPW_CTRL_RST;
      wr_en_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ctrl_q <= WB_DAT_I[7:0];
      if (WB_DAT_I[7:0] == `FDPW_CODE_WR_ON)
      begin
        wr_en_q <= 1'b1;
      end
      else if (WB_DAT_I[7:0] == `FDPW_CODE_WR_OFF)
      begin
        wr_en_q <= 1'b0;
      end
    end
  end

  // Emulation write time, in units of 256 cycles
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      emut_q <= `FDPW_EMUT_RST;
    end
    else if (wb_wr && (WB_ADR_I == `FDPW_EMUT_OFS))
    begin
      if (WB_SEL_I[0])
      begin
        emut_q[7:0] <= WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1])
      begin
        emut_q[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // Aborted flag: write one to clear, a new abort wins
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      abort_q <= 1'b0;
    end
    else if (abort_ev)
    begin
      abort_q <= 1'b1;
    end
    else if (stat_wr && WB_DAT_I[`FDPW_STAT_ABT])
    begin
      abort_q <= 1'b0;
    end
  end

  // Checks
  logic [10:0] wlen_q;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      wlen_q <= 11'd0;
    end
    else
    begin
      wlen_q <= CPU_WAIT ? wlen_q + 11'd1 : 11'd0;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence seq_abort_cause;
    NMI && busy_st;
  endsequence

  sequence seq_abort_effect;
    CPU_WAIT && abort_q && (cnt_q == 7'd0) && !warm_done_q;
  endsequence

  chk_busy_read_blank: assert property (
    p_vld_q && !p_we_q && p_blk_q |=> MEM_ACK && (MEM_RDATA == 8'hff))
    else $error("blocked read did not return blank");

  chk_fetch_swi: assert property (
    SWI_REQ |-> MEM_ACK && (MEM_RDATA == 8'hff) && $past(p_fetch_q))
    else $error("software interrupt without blank fetch");

  chk_read_pass: assert property (
    p_vld_q && !p_we_q && !p_blk_q |=> MEM_RDATA == $past(FL_RDATA))
    else $error("idle read did not pass flash data");

  chk_abort_seq: assert property (
    seq_abort_cause |=> seq_abort_effect)
    else $error("abort did not flag, clear and warm up");

  chk_warm_length: assert property (
    $fell(CPU_WAIT) && !SYS_CLK_SEL && !$past(SYS_CLK_SEL) |->
    wlen_q == 11'd1024)
    else $error("fast warm-up length wrong");

  chk_short_page_kept: assert property (
    NMI && (st_q == fdpw_pkg::ST_FILL) |=> (!FL_ERASE && !FL_WR_EN) [*8])
    else $error("aborted short page was touched");

  chk_warm_holds: assert property (
    $rose(CPU_WAIT) |-> CPU_WAIT [*8])
    else $error("warm-up ended too soon");

  chk_enable_code: assert property (
    ctrl_wr && (WB_DAT_I[7:0] == 8'h3b) |=> wr_en_q)
    else $error("enable code did not enable writes");

  chk_overflow_busy: assert property (
    store && (cnt_nx == 7'd64) |=> busy_st && (cnt_q == 7'd0) ##1 WR_BUSY)
    else $error("64th byte did not start programming");

  chk_first_byte: assert property (
    store && (st_q == fdpw_pkg::ST_IDLE) |=>
    (page_q == $past(MEM_ADDR[15:6])) && (cnt_q != 7'd0))
    else $error("first byte did not select page");

  chk_word_store: assert property (
    store && room2 && (cnt_q < 7'd62) |=> cnt_q == $past(cnt_q) + 7'd2)
    else $error("word store did not take two positions");

  // An abort also drops busy, with no copy behind it
  chk_copy_before_fall: assert property (
    $fell(WR_BUSY) && !$past(NMI) |-> $past(FL_WR_EN))
    else $error("busy fell before the last copy");

endmodule

`default_nettype wire

// file: tb/fdpw_cpu_model.sv
/*
  CPU core model driving the page writer's memory port.
  Assumes every request is answered by a MEM_ACK pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module fdpw_cpu_model (
  input  wire logic        clk,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_word,
  output logic             mem_fetch,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        swi_req
);
  initial
  begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_word  = 1'b0;
    mem_fetch = 1'b0;
    mem_addr  = 16'h0000;
    mem_wdata = 16'h0000;
  end

  // Code runs from RAM with interrupts off
  task automatic access(input logic we, wd, ft, input logic [15:0] a, d,
                        output logic [7:0] rd, output logic swi,
                        output int lat);
    @(posedge clk);
    mem_req   <= 1'b1;
    mem_we    <= we;
    mem_word  <= wd;
    mem_fetch <= ft;
    mem_addr  <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_req <= 1'b0;
    lat = 0;
    while (lat < 20)
    begin
      @(posedge clk);
      lat++;
      if (mem_ack === 1'b1)
        break;
    end
    rd = mem_rdata;
    swi = swi_req;
    // Released address and data must not keep showing the old value
    mem_addr  <= ~a;
    mem_wdata <= ~d;
  endtask
endmodule

`default_nettype wire

// file: tb/tb_top.sv
/*
  Self-checking bench of the flash page writer.
  Assumes a flash array that answers reads in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic        MEM_REQ, MEM_WE, MEM_WORD, MEM_FETCH, MEM_ACK, SWI_REQ;
  logic        NMI, SYS_CLK_SEL, LF_TICK, PROM_MODE, CPU_WAIT, WR_BUSY;
  logic        FL_RD_EN, FL_ERASE, FL_WR_EN, swi;
  logic [3:0]  WB_SEL_I;
  logic [7:0]  WB_ADR_I, MEM_RDATA, FL_RDATA, FL_WR_DATA, rd;
  logic [15:0] MEM_ADDR, MEM_WDATA, FL_RD_ADDR, FL_WR_ADDR;
  logic [31:0] WB_DAT_I, WB_DAT_O, wd;
  logic [9:0]  FL_PAGE, erase_page, wr_hi;
  logic [7:0]  wr_mem [64];
  logic [2:0]  lf_div;
  int          mismatches, samples_checked, erase_cnt, wr_cnt, rd_busy;
  int          lat;

  fdpw_top #(.PROG_CYC(50)) u_fdpw_top (
    .CLK(CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_WORD(MEM_WORD),
    .MEM_FETCH(MEM_FETCH), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .SWI_REQ(SWI_REQ),
    .NMI(NMI), .SYS_CLK_SEL(SYS_CLK_SEL), .LF_TICK(LF_TICK),
    .PROM_MODE(PROM_MODE), .CPU_WAIT(CPU_WAIT), .WR_BUSY(WR_BUSY),
    .FL_RD_EN(FL_RD_EN), .FL_RD_ADDR(FL_RD_ADDR), .FL_RDATA(FL_RDATA),
    .FL_ERASE(FL_ERASE), .FL_PAGE(FL_PAGE), .FL_WR_EN(FL_WR_EN),
    .FL_WR_ADDR(FL_WR_ADDR), .FL_WR_DATA(FL_WR_DATA));

  fdpw_cpu_model u_fdpw_cpu_model (
    .clk(CLK), .mem_req(MEM_REQ), .mem_we(MEM_WE), .mem_word(MEM_WORD),
    .mem_fetch(MEM_FETCH), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
    .mem_rdata(MEM_RDATA), .mem_ack(MEM_ACK), .swi_req(SWI_REQ));

  // Flash array: unselected data changes every cycle
  assign FL_RDATA = FL_RD_EN ? (FL_RD_ADDR[7:0] ^ 8'h5a) : {5'h00, lf_div};

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  always @(posedge CLK)
  begin
    lf_div <= (lf_div == 3'd4) ? 3'd0 : lf_div + 3'd1;
    LF_TICK <= (lf_div == 3'd4);
    if (FL_RD_EN === 1'b1 && WR_BUSY === 1'b1)
      rd_busy++;
    if (FL_ERASE === 1'b1)
    begin
      erase_cnt++;
      erase_page = FL_PAGE;
    end
    if (FL_WR_EN === 1'b1)
    begin
      wr_cnt++;
      wr_hi = FL_WR_ADDR[15:6];
      wr_mem[FL_WR_ADDR[5:0]] = FL_WR_DATA;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic fail_wait;
    mismatches++;
    $display("CHECK FAILED wait expected done seen timeout");
    close_out();
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLK);
      if (WB_ACK_O === 1'b1)
        break;
    end
    wd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    if (n == 20)
      fail_wait();
  endtask

  task automatic mem(input logic we, wrd, ft, input logic [15:0] a, d);
    u_fdpw_cpu_model.access(we, wrd, ft, a, d, rd, swi, lat);
    if (lat >= 20)
      fail_wait();
  endtask

  task automatic wait_stat(input int b, input logic v);
    int n;
    for (n = 0; n < 1000; n++)
    begin
      wb(1'b0, 8'h04, 32'h0);
      if (wd[b] === v)
        break;
    end
    if (n == 1000)
      fail_wait();
  endtask

  // Byte at position p is p ^ v; word stores in between
  task automatic fill_page(input logic [15:0] a0, input logic [7:0] v);
    int i;
    erase_cnt = 0;
    wr_cnt = 0;
    mem(1'b1, 1'b0, 1'b0, a0, {8'h00, v});
    for (i = 1; i < 63; i += 2)
      mem(1'b1, 1'b1, 1'b0, 16'h8000 + 16'((i * 37) & 'h1ff),
          {8'(i + 1) ^ v, 8'(i) ^ v});
    mem(1'b1, 1'b0, 1'b0, a0 ^ 16'h0011, {8'h00, 8'd63 ^ v});
  endtask

  task automatic check_page(input logic [9:0] pg, input logic [7:0] v);
    int p;
    check("erase_count", erase_cnt, 1);
    check("erase_page", erase_page, pg);
    check("write_count", wr_cnt, 64);
    check("write_page", wr_hi, pg);
    for (p = 0; p < 64; p++)
      check("page_byte", wr_mem[p], 8'(p) ^ v);
  endtask

  task automatic nmi_warm(input int lo, hi);
    int n;
    n = 0;
    @(posedge CLK);
    NMI <= 1'b1;
    @(posedge CLK);
    NMI <= 1'b0;
    repeat (2000)
    begin
      @(posedge CLK);
      if (CPU_WAIT === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    check("warm_cycles", n >= lo && n <= hi, 1);
    wb(1'b0, 8'h04, 32'h0);
    check("aborted", wd[2], 1);
    check("count_cleared", wd[13:8], 0);
    wb(1'b1, 8'h04, 32'h4);
    wb(1'b0, 8'h04, 32'h0);
    check("aborted_clear", wd[2], 0);
  endtask

  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0);
    check("ctrl_reset", wd, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    check("emu_time_reset", wd, 32'h0100);
    wb(1'b1, 8'h0c, 32'h3b);
    wb(1'b0, 8'h0c, 32'h0);
    check("unmapped", wd, 32'h0);
    wait_stat(1, 1'b1); // Poll warm-up done first
    $display("test regs done");
  endtask

  task automatic t_load;
    mem(1'b0, 1'b0, 1'b0, 16'h8123, 16'h0);
    check("idle_load", rd, 8'h23 ^ 8'h5a);
    check("idle_swi", swi, 0);
    $display("test load done");
  endtask

  task automatic t_page;
    wb(1'b1, 8'h00, 32'h3b);
    mem(1'b1, 1'b0, 1'b0, 16'h9000, 16'h00ee);
    wb(1'b0, 8'h04, 32'h0);
    check("out_of_range", wd[13:8], 0);
    fill_page(16'h8047, 8'h3c);
    @(negedge CLK);
    check("busy_after_64", WR_BUSY, 1);
    mem(1'b0, 1'b0, 1'b0, 16'h8047, 16'h0);
    check("busy_load", rd, 8'hff);
    mem(1'b0, 1'b0, 1'b1, 16'h8100, 16'h0);
    check("busy_fetch", rd, 8'hff);
    check("busy_swi", swi, 1);
    wait_stat(0, 1'b0);
    check_page(10'h201, 8'h3c);
    wb(1'b1, 8'h00, 32'hcb);
    mem(1'b1, 1'b0, 1'b0, 16'h8000, 16'h0055);
    wb(1'b0, 8'h04, 32'h0);
    check("store_disabled", wd[13:8], 0);
    $display("test page done");
  endtask

  task automatic t_abort_fill;
    int i;
    wb(1'b1, 8'h00, 32'h3b);
    erase_cnt = 0;
    wr_cnt = 0;
    for (i = 0; i < 10; i++)
      mem(1'b1, 1'b0, 1'b0, 16'h8080, 16'(i));
    nmi_warm(1023, 1026);
    check("fill_abort_erase", erase_cnt + wr_cnt, 0);
    wait_stat(1, 1'b1);
    // Warm-up done seen, so a whole new page, 0x207, is written
    wb(1'b1, 8'h00, 32'h3b);
    fill_page(16'h81c5, 8'ha5);
    wait_stat(0, 1'b0);
    check_page(10'h207, 8'ha5);
    wb(1'b1, 8'h00, 32'hcb);
    $display("test abort fill done");
  endtask

  task automatic t_abort_busy;
    @(posedge CLK);
    SYS_CLK_SEL <= 1'b1;
    wb(1'b1, 8'h00, 32'h3b);
    fill_page(16'h8100, 8'h11);
    nmi_warm(34, 46);
    check("busy_stopped", WR_BUSY, 0);
    check("busy_abort_erase", erase_cnt + wr_cnt, 0);
    @(posedge CLK);
    SYS_CLK_SEL <= 1'b0;
    PROM_MODE <= 1'b1;
    wait_stat(1, 1'b1);
    // Serial PROM mode opens the whole flash range to stores
    mem(1'b1, 1'b0, 1'b0, 16'hf000, 16'h0077);
    wb(1'b0, 8'h04, 32'h0);
    check("prom_range", wd[13:8], 1);
    wb(1'b1, 8'h00, 32'hcb);
    $display("test abort busy done");
  endtask

  initial
  begin
    RST_B = 1'b0;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I = 1'b0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hf;
    WB_DAT_I = 32'h0;
    NMI = 1'b0;
    SYS_CLK_SEL = 1'b0;
    LF_TICK = 1'b0;
    PROM_MODE = 1'b0;
    lf_div = 3'd0;
    mismatches = 0;
    samples_checked = 0;
    rd_busy = 0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs();
    t_load();
    t_page();
    t_abort_fill();
    t_abort_busy();
    check("reads_while_busy", rd_busy, 0);
    close_out();
  end
endmodule

`default_nettype wire
